// ===== core/msomap_top.sv
`timescale 1ns/1ns
module msomap_top
  import msomap_pkg::*;
#(
  parameter int unsigned WIDTH = WORD_W
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic [WIDTH-1:0]     drive_status,
  input  wire logic [WIDTH-1:0]     limit_active,
  input  wire logic [WIDTH-1:0]     digin_state,
  input  wire logic                 cfg_we,
  input  wire logic [1:0]           cfg_chan,
  input  wire logic [FIELD_W-1:0]   cfg_sel,
  input  wire logic [WIDTH-1:0]     cfg_mask,
  input  wire logic                 cfg_invert,
  input  wire logic                 poles_we,
  input  wire logic [7:0]           poles_wdata,
  output logic                      poles_reject_q,
  output logic [7:0]                poles_q,
  output logic [FIELD_W-1:0]        sel_rd_q [NUM_OUTPUTS],
  output logic [NUM_OUTPUTS-1:0]    dout
);

  // Per-output configuration, one register set for each pin
  logic [FIELD_W-1:0]     sel_q          [NUM_OUTPUTS];
  logic [FIELD_W-1:0]     sel_d          [NUM_OUTPUTS];
  logic [WIDTH-1:0]       mask_q         [NUM_OUTPUTS];
  logic [WIDTH-1:0]       mask_d         [NUM_OUTPUTS];
  logic                   invert_q       [NUM_OUTPUTS];
  logic                   invert_d       [NUM_OUTPUTS];
  logic [NUM_OUTPUTS-1:0] chan_hit;
  logic                   cfg_chan_ok;

  // Source word picked for each output
  logic [WIDTH-1:0]       src            [NUM_OUTPUTS];

  // Pole count and the outcome of its last write
  logic [7:0]             poles_d;
  logic                   poles_reject_d;
  logic                   poles_ok;
  logic [WIDTH-1:0]       pole_word;

  // Field number to source word; the pole count is a field too, so a pin can follow it
  function automatic logic [WIDTH-1:0] pick_word(input logic [FIELD_W-1:0] sel,
                                                  input logic [WIDTH-1:0]   ds,
                                                  input logic [WIDTH-1:0]   la,
                                                  input logic [WIDTH-1:0]   di,
                                                  input logic [WIDTH-1:0]   pc);
    logic [WIDTH-1:0] w;
    w = '0;
    case (sel)
      FIELD_DRIVE_STATUS: w = ds;
      FIELD_LIMIT_ACTIVE: w = la;
      FIELD_DIGIN_STATE:  w = di;
      FIELD_POLE_COUNT:   w = pc;
      default:            w = '0; // Unknown field numbers read as zero
    endcase
    return w;
  endfunction : pick_word

  // Reset tables, indexed by output number
  function automatic logic [FIELD_W-1:0] reset_sel(input int unsigned i);
    case (i)
      0:       return RST_SEL_OUT1;
      1:       return RST_SEL_OUT2;
      2:       return RST_SEL_OUT3;
      default: return RST_SEL_OUT3;
    endcase
  endfunction : reset_sel

  function automatic logic [31:0] reset_mask(input int unsigned i);
    case (i)
      0:       return RST_MASK_OUT1;
      1:       return RST_MASK_OUT2;
      2:       return RST_MASK_OUT3;
      default: return RST_MASK_OUT3;
    endcase
  endfunction : reset_mask

  function automatic logic reset_invert(input int unsigned i);
    case (i)
      0:       return RST_INVERT;
      1:       return RST_INVERT;
      2:       return RST_INVERT;
      default: return RST_INVERT;
    endcase
  endfunction : reset_invert

  // Write decode for one output; the channel range is checked apart
  function automatic logic chan_write(input logic        we,
                                      input logic [1:0]  chan,
                                      input int unsigned idx);
    return we && (chan == 2'(idx));
  endfunction : chan_write

  function automatic logic pole_in_range(input logic [7:0] v);
    return (v >= POLES_MIN) && (v <= POLES_MAX);
  endfunction : pole_in_range

  // Out-of-range pole writes are dropped, not clamped, so a typing slip never reaches the motor model
  always_comb begin
    poles_ok = pole_in_range(poles_wdata);
  end

  always_comb begin
    poles_d = poles_q;
    if (poles_we && poles_ok) begin
      poles_d = poles_wdata;
    end
  end

  // The flag tells only about the last write, so a good write clears it
  always_comb begin
    poles_reject_d = poles_reject_q;
    if (poles_we) begin
      poles_reject_d = !poles_ok;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      poles_q <= RST_POLES;
    end else begin
      poles_q <= poles_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      poles_reject_q <= 1'b0;
    end else begin
      poles_reject_q <= poles_reject_d;
    end
  end

  // Zero-extended so the pole count can stand beside the full-width words
  assign pole_word = WIDTH'(poles_q);

  // Channel numbers past the last output address nothing, so such a write is dropped
  assign cfg_chan_ok = (cfg_chan < 2'(NUM_OUTPUTS));

  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : g_out
      assign chan_hit[g] = cfg_chan_ok && chan_write(cfg_we, cfg_chan, g);

      // Selection, mask and invert of one output change together in one write
      always_comb begin
        sel_d[g] = sel_q[g];
        if (chan_hit[g]) begin
          sel_d[g] = cfg_sel;
        end
      end

      always_comb begin
        mask_d[g] = mask_q[g];
        if (chan_hit[g]) begin
          mask_d[g] = cfg_mask;
        end
      end

      always_comb begin
        invert_d[g] = invert_q[g];
        if (chan_hit[g]) begin
          invert_d[g] = cfg_invert;
        end
      end

      // Asynchronous reset loads each register from the tables above
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          sel_q[g] <= reset_sel(g);
        end else begin
          sel_q[g] <= sel_d[g];
        end
      end

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          mask_q[g] <= WIDTH'(reset_mask(g));
        end else begin
          mask_q[g] <= mask_d[g];
        end
      end

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          invert_q[g] <= reset_invert(g);
        end else begin
          invert_q[g] <= invert_d[g];
        end
      end

      // Readback comes from the selection register itself, so it never disagrees with the source in use
      assign sel_rd_q[g] = sel_q[g];

      always_comb begin
        src[g] = pick_word(sel_q[g], drive_status, limit_active, digin_state, pole_word);
      end

      // Each channel registers its pin, so a selection change never glitches it
      msomap_channel #(
        .WIDTH (WIDTH)
      ) u_chan (
        .clk      (clk),
        .rstn     (rstn),
        .src_word (src[g]),
        .mask     (mask_q[g]),
        .invert   (invert_q[g]),
        .pin_q    (dout[g])
      );
    end
  endgenerate

endmodule : msomap_top

// ===== core/msomap_pkg.sv
package msomap_pkg;

  localparam int unsigned NUM_OUTPUTS   = 3;
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned FIELD_W       = 8;

  // Field numbers of the internal parameter words that can be routed out
  localparam logic [7:0] FIELD_DRIVE_STATUS  = 8'h00;
  localparam logic [7:0] FIELD_LIMIT_ACTIVE  = 8'h01;
  localparam logic [7:0] FIELD_DIGIN_STATE   = 8'h02;
  localparam logic [7:0] FIELD_POLE_COUNT    = 8'h03;
  localparam int unsigned NUM_FIELDS         = 4;

  // Values after reset
  localparam logic [7:0]  RST_SEL_OUT1   = FIELD_DRIVE_STATUS;
  localparam logic [7:0]  RST_SEL_OUT2   = FIELD_LIMIT_ACTIVE;
  localparam logic [7:0]  RST_SEL_OUT3   = FIELD_DIGIN_STATE;
  localparam logic [31:0] RST_MASK_OUT1  = 32'h0000_0080;
  localparam logic [31:0] RST_MASK_OUT2  = 32'h0000_000D;
  localparam logic [31:0] RST_MASK_OUT3  = 32'h0000_0000;
  localparam logic        RST_INVERT     = 1'b0;

  // Motor pole count limits and reset value
  localparam logic [7:0]  POLES_MIN      = 8'h02;
  localparam logic [7:0]  POLES_MAX      = 8'h24;
  localparam logic [7:0]  RST_POLES      = 8'h02;

endpackage : msomap_pkg

// ===== core/msomap_channel.sv
`timescale 1ns/1ns
module msomap_channel
  import msomap_pkg::*;
#(
  parameter int unsigned WIDTH = WORD_W
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] src_word,
  input  wire logic [WIDTH-1:0] mask,
  input  wire logic             invert,
  output logic                  pin_q
);

  logic pin_d;

  always_comb begin
    pin_d = (|(src_word & mask)) ^ invert;
  end

  // Registered so the pin never glitches while a selection changes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

endmodule : msomap_channel

// ===== sim/msomap_lamps.sv
`timescale 1ns/1ns
// Indicator lamps have no latch of their own, so a lamp shows its pin at once
module msomap_lamps (
  input  logic [2:0] dout,
  output logic [2:0] lit
);
  assign lit = dout;
endmodule : msomap_lamps

// ===== sim/msomap_properties.sv
`timescale 1ns/1ns
module msomap_properties
  import msomap_pkg::*;
(
  input logic        clk,
  input logic        rstn,
  input logic        cfg_we,
  input logic [1:0]  cfg_chan,
  input logic [7:0]  cfg_sel,
  input logic [31:0] cfg_mask,
  input logic        cfg_invert,
  input logic        poles_we,
  input logic [7:0]  poles_wdata,
  input logic        poles_reject_q,
  input logic [7:0]  poles_q,
  input logic [7:0]  sel_rd_q [3],
  input logic [2:0]  dout
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire ok = poles_wdata >= POLES_MIN && poles_wdata <= POLES_MAX;
  // A second write in the gap reaches the pin only after the checked cycle; it is excluded all the same
  wire z = cfg_we && cfg_chan == 2'h0 && cfg_mask == 32'h0;
  a_pole_range: assert property (poles_q >= POLES_MIN && poles_q <= POLES_MAX) else $error("poles");
  a_pole_bad: assert property (poles_we && !ok |=> poles_reject_q && $stable(poles_q)) else $error("bad");
  a_pole_good: assert property (poles_we && ok |=> poles_q == $past(poles_wdata)) else $error("good");
  a_pole_clear: assert property (poles_we && ok |=> !poles_reject_q) else $error("reject flag kept");
  a_sel_write: assert property (cfg_we && cfg_chan == 2'h0 |=> sel_rd_q[0] == $past(cfg_sel)) else $error("sel");
  a_chan_drop: assert property (cfg_we && cfg_chan == 2'h3 |=> $stable(sel_rd_q[2])) else $error("chan");
  a_mask_zero: assert property (z && !cfg_invert ##1 !cfg_we |=> !dout[0]) else $error("mask");
  a_invert_on: assert property (z && cfg_invert ##1 !cfg_we |=> dout[0]) else $error("inv");
endmodule : msomap_properties

// ===== sim/msomap_top_tb.sv
`timescale 1ns/1ns
bind msomap_top msomap_properties u_chk (.*);
module msomap_top_tb;
  import msomap_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, cfg_we = 1'b0, cfg_invert = 1'b0, poles_we = 1'b0, poles_reject_q;
  logic [1:0] cfg_chan = 2'h0;
  logic [7:0] cfg_sel = 8'h00, poles_wdata = 8'h00, poles_q, sel_rd_q [3];
  logic [31:0] drive_status = 32'h80, limit_active = 32'h0, digin_state = 32'h0, cfg_mask = 32'h0;
  logic [2:0] dout, lit;
  int n_fail = 0, comparisons = 0;
  always #10 clk = ~clk;
  msomap_top u_dut (.*);
  msomap_lamps u_lamps (.dout, .lit);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task cfg(input logic [1:0] c, input logic [7:0] s, input logic [31:0] m, input logic i, input logic [2:0] e);
    @(negedge clk);
    {cfg_we, cfg_chan, cfg_sel, cfg_mask, cfg_invert} = {1'b1, c, s, m, i};
    @(negedge clk);
    cfg_we = 1'b0;
    @(negedge clk);
    chk("lit", {29'h0, e}, {29'h0, lit});
  endtask : cfg
  task pole(input logic [7:0] v, input logic [8:0] e);
    @(negedge clk);
    {poles_we, poles_wdata} = {1'b1, v};
    @(negedge clk);
    poles_we = 1'b0;
    chk("poles", {23'h0, e}, {23'h0, poles_reject_q, poles_q});
  endtask : pole
  task wrap_up;
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("sel", 32'h00020100, {8'h00, sel_rd_q[2], sel_rd_q[1], sel_rd_q[0]});
    chk("lit", 32'h1, {29'h0, lit});
    cfg(2'h0, FIELD_DIGIN_STATE, 32'h1, 1'b0, 3'h0);
    digin_state = 32'h1;
    cfg(2'h0, FIELD_DIGIN_STATE, 32'h0, 1'b0, 3'h0);
    cfg(2'h0, FIELD_DIGIN_STATE, 32'h0, 1'b1, 3'h1);
    cfg(2'h3, FIELD_DRIVE_STATUS, 32'hFFFFFFFF, 1'b1, 3'h1);
    cfg(2'h2, FIELD_DIGIN_STATE, 32'h1, 1'b0, 3'h5);
    cfg(2'h1, FIELD_DRIVE_STATUS, 32'h80, 1'b0, 3'h7);
    pole(8'h24, 9'h024);
    pole(8'h25, 9'h124);
    pole(8'h01, 9'h124);
    pole(8'h02, 9'h002);
    cfg(2'h0, FIELD_POLE_COUNT, 32'h1, 1'b0, 3'h6);
    cfg(2'h0, FIELD_POLE_COUNT, 32'h2, 1'b0, 3'h7);
    cfg(2'h1, 8'h07, 32'hFFFFFFFF, 1'b0, 3'h5);
    chk("sel", 32'h00020703, {8'h00, sel_rd_q[2], sel_rd_q[1], sel_rd_q[0]});
    cfg(2'h2, FIELD_DIGIN_STATE, 32'h1, 1'b1, 3'h1);
    pole(8'h00, 9'h102);
    // Second reset in mid-run: every setting must fall back to its default
    @(negedge clk);
    {rstn, limit_active} = {1'b0, 32'h4};
    @(negedge clk);
    chk("lit", 32'h0, {29'h0, lit});
    chk("poles", 32'h002, {23'h0, poles_reject_q, poles_q});
    rstn = 1'b1;
    @(negedge clk);
    chk("sel", 32'h00020100, {8'h00, sel_rd_q[2], sel_rd_q[1], sel_rd_q[0]});
    chk("lit", 32'h3, {29'h0, lit});
    wrap_up();
  end
endmodule : msomap_top_tb
